// File: rtl/freq_sel_consts.vh
// Constants for the frequency reference selector
// How it works
// - Auxiliary selector accepts codes zero to nine
// - Communication code takes host frequency reference
// - Auxiliary alone behaves like main source
// - Digital auxiliary ignores preset, adds adjustments
// - Analog/pulse full scale maps to auxiliary range
// - Range base: zero max frequency, one main
// - Range percent 0-150, used in modes 1,3,4
// - Span follows main reference continuously
// - Units digit zero selects main reference
// - Units digit one selects operation result
// - Units two switches main and auxiliary
// - Units three switches main and result
// - Units four switches auxiliary and result
// - Tens digit: sum, difference, maximum, minimum
// - Tens zero: result is the sum
// - Max/min compare absolute values
// - Offset frequency added to operation result
`ifndef FREQ_SEL_CONSTS_VH
`define FREQ_SEL_CONSTS_VH
`define FW 16
`define SRC_DIG_KEEP 4'h0
`define SRC_DIG_LOSE 4'h1
`define SRC_AN1 4'h2
`define SRC_AN2 4'h3
`define SRC_AN3 4'h4
`define SRC_PULSE 4'h5
`define SRC_MULTI 4'h6
`define SRC_PLC 4'h7
`define SRC_PID 4'h8
`define SRC_COMM 4'h9
`define UNIT_MAIN 4'h0
`define UNIT_OPER 4'h1
`define UNIT_SW_MA 4'h2
`define UNIT_SW_MO 4'h3
`define UNIT_SW_AO 4'h4
`define OP_SUM 4'h0
`define OP_DIFF 4'h1
`define OP_MAX 4'h2
`define OP_MIN 4'h3
`define PCT_MAX 8'h96
`define PCT_FULL 8'h64
`define FULL_SCALE 16'h7fff
`define UNITS_MSB 3
`define UNITS_LSB 0
`define TENS_MSB 7
`define TENS_LSB 4
`define NO_SOURCE 16'h0000
`define TARGET_RST 16'h0000
`define FLAG_RST 1'b0
`endif

// File: rtl/aux_scaler.v
// Scales a full-scale input fraction into the auxiliary span
`timescale 1ns/100ps
`include "freq_sel_consts.vh"
module aux_scaler (
  input wire signed [15:0] in_frac,
  input wire signed [15:0] base,
  input wire [7:0] percent,
  output wire signed [15:0] scaled
);
  wire [7:0] pct_lim;
  wire signed [15:0] span;
  wire signed [31:0] span_w;
  wire signed [31:0] prod;
  // Percent clamped at its top so an out-of-range setting cannot widen the span
  assign pct_lim = (percent > `PCT_MAX) ? `PCT_MAX : percent;
  assign span_w = (base * $signed({24'h00_0000, pct_lim})) / $signed({24'h00_0000, `PCT_FULL});
  assign span = span_w[15:0];
  // Full scale of the input equals the whole span
  assign prod = (in_frac * span) / $signed({16'h0000, `FULL_SCALE});
  assign scaled = prod[15:0];
endmodule

// File: rtl/frequency_reference_selector.v
// Main/auxiliary frequency source selection and combination
`timescale 1ns/100ps
`include "freq_sel_consts.vh"
module frequency_reference_selector (
  input wire clk,
  input wire nrst,
  input wire [3:0] main_source_select,
  input wire [3:0] aux_source_select,
  input wire aux_range_reference,
  input wire [7:0] aux_range_percent,
  input wire [7:0] combination_mode,
  input wire signed [15:0] preset_frequency,
  input wire signed [15:0] offset_frequency,
  input wire signed [15:0] max_frequency,
  input wire signed [15:0] updown_adjust,
  input wire signed [15:0] analog_input_one,
  input wire signed [15:0] analog_input_two,
  input wire signed [15:0] analog_input_three,
  input wire signed [15:0] pulse_digital_input,
  input wire signed [15:0] multi_stage_frac,
  input wire signed [15:0] plc_frac,
  input wire signed [15:0] pid_frac,
  input wire signed [15:0] comm_frequency,
  input wire comm_card_present,
  input wire freq_switch,
  output wire signed [15:0] target_frequency,
  output wire source_conflict,
  output wire comm_missing,
  output wire mode_invalid
);
  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_n;
  wire [3:0] units;
  wire [3:0] tens;
  wire signed [15:0] main_ref;
  wire signed [15:0] aux_alone;
  wire signed [15:0] aux_sup;
  wire signed [15:0] aux_frac;
  wire signed [15:0] range_base;
  wire signed [15:0] aux_scaled;
  wire aux_analog;
  wire aux_digital;
  reg signed [15:0] oper_d;
  reg signed [15:0] target_d;
  reg signed [15:0] target_q;
  reg conflict_q;
  reg comm_missing_q;
  reg mode_invalid_q;
  reg conflict_d;
  reg comm_missing_d;
  reg mode_invalid_d;
  wire signed [15:0] oper_sum;
  wire signed [15:0] oper_diff;
  wire signed [15:0] oper_max;
  wire signed [15:0] oper_min;
  wire main_comm;
  wire aux_comm;

  // Reset released through two flops, asserted immediately
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // Decimal digits of the combination mode
  function [3:0] bcd_units;
    input [7:0] v;
    begin
      bcd_units = v[`UNITS_MSB:`UNITS_LSB];
    end
  endfunction

  function [3:0] bcd_tens;
    input [7:0] v;
    begin
      bcd_tens = v[`TENS_MSB:`TENS_LSB];
    end
  endfunction

  function signed [15:0] frac_to_hz;
    input signed [15:0] frac;
    input signed [15:0] fmax;
    reg signed [31:0] p;
    begin
      p = (frac * fmax) / $signed({16'h0000, `FULL_SCALE});
      frac_to_hz = p[15:0];
    end
  endfunction

  // One source decoder shared by main and auxiliary, so the codes mean the same
  function signed [15:0] source_value;
    input [3:0] sel;
    input signed [15:0] preset;
    input signed [15:0] adj;
    input signed [15:0] a1;
    input signed [15:0] a2;
    input signed [15:0] a3;
    input signed [15:0] pl;
    input signed [15:0] ms;
    input signed [15:0] pc;
    input signed [15:0] pd;
    input signed [15:0] cm;
    input signed [15:0] fmax;
    begin
      case (sel)
        `SRC_DIG_KEEP: source_value = preset + adj;
        `SRC_DIG_LOSE: source_value = preset + adj;
        `SRC_AN1: source_value = frac_to_hz(a1, fmax);
        `SRC_AN2: source_value = frac_to_hz(a2, fmax);
        `SRC_AN3: source_value = frac_to_hz(a3, fmax);
        `SRC_PULSE: source_value = frac_to_hz(pl, fmax);
        `SRC_MULTI: source_value = frac_to_hz(ms, fmax);
        `SRC_PLC: source_value = frac_to_hz(pc, fmax);
        `SRC_PID: source_value = frac_to_hz(pd, fmax);
        `SRC_COMM: source_value = cm;
        default: source_value = `NO_SOURCE;
      endcase
    end
  endfunction

  function signed [15:0] abs16;
    input signed [15:0] v;
    begin
      abs16 = v[15] ? -v : v;
    end
  endfunction

  // Codes that mean the up/down digital setting
  function is_digital;
    input [3:0] sel;
    begin
      is_digital = (sel == `SRC_DIG_KEEP) || (sel == `SRC_DIG_LOSE);
    end
  endfunction

  // Codes whose full scale maps onto the auxiliary span
  function is_scaled;
    input [3:0] sel;
    begin
      is_scaled = (sel == `SRC_AN1) || (sel == `SRC_AN2) || (sel == `SRC_AN3) ||
        (sel == `SRC_PULSE);
    end
  endfunction

  // Host channel code
  function is_comm;
    input [3:0] sel;
    begin
      is_comm = (sel == `SRC_COMM);
    end
  endfunction

  // Anything past the last channel code is flagged, never trapped
  function code_bad;
    input [3:0] sel;
    begin
      code_bad = (sel > `SRC_COMM);
    end
  endfunction

  // Input feeding the span scaler; pulse is the fall-through
  function signed [15:0] scaled_input;
    input [3:0] sel;
    input signed [15:0] a1;
    input signed [15:0] a2;
    input signed [15:0] a3;
    input signed [15:0] pl;
    begin
      case (sel)
        `SRC_AN1: scaled_input = a1;
        `SRC_AN2: scaled_input = a2;
        `SRC_AN3: scaled_input = a3;
        default: scaled_input = pl;
      endcase
    end
  endfunction

  // Ties go to the main reference
  function signed [15:0] pick_larger;
    input signed [15:0] x;
    input signed [15:0] y;
    begin
      pick_larger = (abs16(x) >= abs16(y)) ? x : y;
    end
  endfunction

  function signed [15:0] pick_smaller;
    input signed [15:0] x;
    input signed [15:0] y;
    begin
      pick_smaller = (abs16(x) <= abs16(y)) ? x : y;
    end
  endfunction

  assign units = bcd_units(combination_mode);
  assign tens = bcd_tens(combination_mode);

  assign main_ref = source_value(
    main_source_select,
    preset_frequency,
    updown_adjust,
    analog_input_one,
    analog_input_two,
    analog_input_three,
    pulse_digital_input,
    multi_stage_frac,
    plc_frac,
    pid_frac,
    comm_frequency,
    max_frequency
  );

  // Used alone, the auxiliary source decodes exactly like the main one
  assign aux_alone = source_value(
    aux_source_select,
    preset_frequency,
    updown_adjust,
    analog_input_one,
    analog_input_two,
    analog_input_three,
    pulse_digital_input,
    multi_stage_frac,
    plc_frac,
    pid_frac,
    comm_frequency,
    max_frequency
  );

  assign aux_digital = is_digital(aux_source_select);
  assign aux_analog = is_scaled(aux_source_select);
  assign main_comm = is_comm(main_source_select);
  assign aux_comm = is_comm(aux_source_select);

  assign aux_frac = scaled_input(aux_source_select, analog_input_one, analog_input_two,
    analog_input_three, pulse_digital_input);

  // Base taken live from the main reference, so the span tracks it every cycle
  assign range_base = aux_range_reference ? main_ref : max_frequency;

  aux_scaler u_scaler (
    .in_frac(aux_frac),
    .base(range_base),
    .percent(aux_range_percent),
    .scaled(aux_scaled)
  );

  // In superposition a digital auxiliary is only the up/down trim; preset unused
  assign aux_sup = aux_digital ? updown_adjust :
    aux_analog ? aux_scaled : aux_alone;

  // Each operation formed on its own, so the tens digit only steers a mux
  assign oper_sum = main_ref + aux_sup;
  assign oper_diff = main_ref - aux_sup;
  assign oper_max = pick_larger(main_ref, aux_sup);
  assign oper_min = pick_smaller(main_ref, aux_sup);

  // Main/auxiliary operation plus offset
  always @* begin
    oper_d = oper_sum;
    case (tens)
      `OP_SUM: oper_d = oper_sum;
      `OP_DIFF: oper_d = oper_diff;
      `OP_MAX: oper_d = oper_max;
      `OP_MIN: oper_d = oper_min;
      // Out-of-range tens digit falls back to the sum and raises the flag
      default: oper_d = oper_sum;
    endcase
    oper_d = oper_d + offset_frequency;
  end

  always @* begin
    case (units)
      `UNIT_MAIN: target_d = main_ref;
      `UNIT_OPER: target_d = oper_d;
      `UNIT_SW_MA: target_d = freq_switch ? aux_alone : main_ref;
      `UNIT_SW_MO: target_d = freq_switch ? oper_d : main_ref;
      `UNIT_SW_AO: target_d = freq_switch ? oper_d : aux_alone;
      default: target_d = main_ref;
    endcase
  end

  // Flags only; the configuration is still obeyed
  always @* begin
    conflict_d = (main_source_select == aux_source_select);
    comm_missing_d = !comm_card_present && (main_comm || aux_comm);
    mode_invalid_d = (units > `UNIT_SW_AO) || (tens > `OP_MIN) ||
      code_bad(aux_source_select) || code_bad(main_source_select);
  end

  // Registered once per control cycle; any input change shows one edge later
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target_q <= `TARGET_RST;
      conflict_q <= `FLAG_RST;
      comm_missing_q <= `FLAG_RST;
      mode_invalid_q <= `FLAG_RST;
    end else begin
      target_q <= target_d;
      conflict_q <= conflict_d;
      comm_missing_q <= comm_missing_d;
      mode_invalid_q <= mode_invalid_d;
    end
  end

  // Outputs straight from the flops, no logic after them
  assign target_frequency = target_q;
  assign source_conflict = conflict_q;
  assign comm_missing = comm_missing_q;
  assign mode_invalid = mode_invalid_q;
endmodule

// File: verification/freq_ref_monitor.sv
// Assertion checker for the frequency reference selector
`timescale 1ns/100ps
module freq_ref_monitor (
  input wire clk,
  input wire nrst,
  input wire [3:0] main_source_select,
  input wire [3:0] aux_source_select,
  input wire [7:0] combination_mode,
  input wire signed [15:0] offset_frequency,
  input wire signed [15:0] updown_adjust,
  input wire signed [15:0] comm_frequency,
  input wire comm_card_present,
  input wire freq_switch,
  input wire signed [15:0] target_frequency,
  input wire source_conflict
);
  reg [2:0] up_q;
  wire [7:0] md = combination_mode;
  wire [15:0] cm = comm_frequency;
  wire mc = main_source_select == 4'h9 && comm_card_present && aux_source_select < 4'h2;
  wire ac = aux_source_select == 4'h9 && comm_card_present;
  wire [15:0] s = cm + updown_adjust + offset_frequency;
  wire [15:0] d = cm - updown_adjust + offset_frequency;
  // Outputs sit at zero for a few edges after release
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      up_q <= 3'h0;
    else if (up_q != 3'h7)
      up_q <= up_q + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst || up_q < 3'h5);
  AST_MAIN: assert property (md == 8'h00 && mc |=> target_frequency == $past(cm))
    else $error("main reference not passed");
  AST_SUM: assert property (md == 8'h01 && mc |=> target_frequency == $past(s))
    else $error("sum result wrong");
  AST_DIFF: assert property (md == 8'h11 && mc |=> target_frequency == $past(d))
    else $error("difference result wrong");
  AST_SWM: assert property (md == 8'h02 && mc && !freq_switch |=> target_frequency == $past(cm))
    else $error("switch kept main wrong");
  AST_SWA: assert property (md == 8'h02 && ac && freq_switch |=> target_frequency == $past(cm))
    else $error("switch to auxiliary wrong");
  AST_MIX3: assert property (md == 8'h03 && mc && freq_switch |=> target_frequency == $past(s))
    else $error("main or result switch wrong");
  AST_MIX4: assert property (md == 8'h04 && ac && !freq_switch |=> target_frequency == $past(cm))
    else $error("auxiliary or result switch wrong");
  AST_CONF: assert property (source_conflict == $past(main_source_select == aux_source_select))
    else $error("conflict flag wrong");
endmodule

// File: verification/source_panel.sv
// Model of the analog, pulse, stage, loop and host sources
`timescale 1ns/100ps
module source_panel (
  input wire clk,
  output logic signed [15:0] v [8]
);
  // Fresh samples each cycle, so a stale source shows up at once
  always @(posedge clk) begin
    for (int i = 0; i < 7; i++) v[i] <= 16'($urandom);
    v[7] <= 16'($urandom % 4096);
  end
endmodule

// File: verification/frequency_reference_selector_test.sv
// Self-checking bench for the frequency reference selector
`timescale 1ns/100ps
module frequency_reference_selector_test;
  logic clk = 0, nrst = 0, rr = 0, card = 1, fs = 0;
  logic [3:0] ms = 0, as = 0;
  logic [7:0] pct = 0, md = 0;
  logic signed [15:0] pre = 0, off = 0, mx = 0, adj = 0, tgt;
  logic signed [15:0] v [8];
  logic sc, cmis, minv;
  int errors = 0, check_count = 0, cyc = 0;
  source_panel P (.clk(clk), .v(v));
  frequency_reference_selector DUT (.clk(clk), .nrst(nrst), .main_source_select(ms),
    .aux_source_select(as), .aux_range_reference(rr), .aux_range_percent(pct),
    .combination_mode(md), .preset_frequency(pre), .offset_frequency(off),
    .max_frequency(mx), .updown_adjust(adj), .analog_input_one(v[0]),
    .analog_input_two(v[1]), .analog_input_three(v[2]), .pulse_digital_input(v[3]),
    .multi_stage_frac(v[4]), .plc_frac(v[5]), .pid_frac(v[6]), .comm_frequency(v[7]),
    .comm_card_present(card), .freq_switch(fs), .target_frequency(tgt),
    .source_conflict(sc), .comm_missing(cmis), .mode_invalid(minv));
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (++cyc > 5000) begin
    errors++;
    wrap_up();
  end
  function automatic int src(logic [3:0] c, int sp, bit sup);
    if (c > 9) return 0;
    if (c < 2) return sup ? adj : pre + adj;
    if (c == 9) return v[7];
    return v[c - 2] * ((sup && c < 6) ? sp : mx) / 32767;
  endfunction
  function automatic logic [15:0] want();
    int m, a, y, r, am, aa;
    m = src(ms, 0, 0);
    y = src(as, 0, 0);
    a = src(as, (rr ? m : int'(mx)) * int'(pct > 150 ? 150 : pct) / 100, 1);
    am = m < 0 ? -m : m;
    aa = a < 0 ? -a : a;
    case (md[7:4])
      1: r = m - a;
      2: r = am >= aa ? m : a;
      3: r = am <= aa ? m : a;
      default: r = m + a;
    endcase
    r = r + off;
    case (md[3:0])
      1: return 16'(r);
      2: return 16'(fs ? y : m);
      3: return 16'(fs ? r : m);
      4: return 16'(fs ? r : y);
      default: return 16'(m);
    endcase
  endfunction
  task automatic check(string n, logic [15:0] e, logic [15:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step(bit t);
    logic [15:0] e;
    logic c;
    e = want();
    c = ms == as;
    @(posedge clk);
    #1;
    if (t) check("target", e, tgt);
    check("conflict", {15'h0, c}, {15'h0, sc});
  endtask
  task automatic rnd();
    ms = $urandom % 2 ? 4'h9 : 4'($urandom % 10);
    as = 4'($urandom % 10);
    md = {4'($urandom % 4), 4'($urandom % 5)};
    rr = 1'($urandom);
    fs = 1'($urandom);
    pct = 8'($urandom);
    pre = 16'($urandom % 4096);
    adj = 16'(int'($urandom % 4096) - 2048);
    off = 16'(int'($urandom % 4096) - 2048);
    mx = 16'($urandom % 16384);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(40066));
    repeat (2) @(posedge clk);
    #1 nrst = 1;
    repeat (4) @(posedge clk);
    #1;
    // Corner: same code twice, bad units digit, no card fitted
    rnd();
    ms = 4'h9;
    as = 4'h9;
    md = 8'h35;
    card = 0;
    step(0);
    check("invalid", 16'h1, {15'h0, minv});
    check("comm_missing", 16'h1, {15'h0, cmis});
    card = 1;
    // Corner: main code past the last channel, tens digit past minimum
    rnd();
    ms = 4'hc;
    md = 8'h40;
    step(1);
    check("invalid", 16'h1, {15'h0, minv});
    repeat (3000) begin
      rnd();
      step(1);
      check("invalid", 16'h0, {15'h0, minv});
      check("comm_missing", 16'h0, {15'h0, cmis});
    end
    wrap_up();
  end
endmodule
bind frequency_reference_selector freq_ref_monitor mon (.clk, .nrst, .main_source_select,
  .aux_source_select, .combination_mode, .offset_frequency, .updown_adjust,
  .comm_frequency, .comm_card_present, .freq_switch, .target_frequency, .source_conflict);
